// ==== src/rtccsr_pkg.sv ====
// rtccsr_pkg: constants and carrier types for the rtc control,
// status and trickle-charge register block.
// assumes: imported by rtccsr_regs and the testbench; no clocking of its own.
package rtccsr_pkg;
  // register pointers (low nibble of the serial address)
  localparam logic [3:0] ADDR_CTRL = 4'hd;
  localparam logic [3:0] ADDR_STAT = 4'he;
  localparam logic [3:0] ADDR_TCR = 4'hf;
  // first-power-up values
  localparam logic [7:0] CTRL_RST = 8'h18;
  localparam logic [7:0] STAT_RST = 8'h80;
  localparam logic [7:0] TCR_RST = 8'h00;
  // writable control bits; bits 6 and 1 stay zero
  localparam logic [7:0] CTRL_WMASK = 8'hbd;
  // control field positions
  localparam int CTRL_OSCD = 7;
  localparam int CTRL_BBO = 5;
  localparam int CTRL_RSH = 4;
  localparam int CTRL_RSL = 3;
  localparam int CTRL_MODE = 2;
  localparam int CTRL_AIE = 0;
  // status field positions
  localparam int STAT_OSF = 7;
  localparam int STAT_AF = 0;
  // address byte direction bit
  localparam int WR_BIT = 7;
  // trickle-charge codes
  localparam logic [3:0] TCR_KEY = 4'ha;
  localparam logic [1:0] DS_NONE = 2'h1;
  localparam logic [1:0] DS_ONE = 2'h2;
  localparam logic [1:0] RESISTOR_SELECT_FIELD_OFF = 2'h0;
  // rate codes and divider taps off the 32.768 khz crystal
  localparam logic [1:0] RATE_1HZ = 2'h0;
  localparam logic [1:0] RATE_4K = 2'h1;
  localparam logic [1:0] RATE_8K = 2'h2;
  localparam int DIV_W = 15;
  localparam int TAP_1HZ = 14;
  localparam int TAP_4K = 2;
  localparam int TAP_8K = 1;
  // output-pin variants
  localparam logic [1:0] VAR_COMBINED = 2'h0;
  localparam logic [1:0] VAR_NO_OUT = 2'h1;
  localparam logic [1:0] VAR_SPLIT = 2'h2;
  // async input slots and their reset levels
  localparam int AS_CSN = 0;
  localparam int AS_WTGL = 1;
  localparam int AS_VCC = 2;
  localparam int AS_OSC = 3;
  localparam int AS_XTAL = 4;
  localparam int AS_N = 5;
  localparam logic [4:0] AS_RST = 5'h01;
  // serial frame phase; addr -> write flips one bit, addr -> read flips two
  typedef enum logic [1:0] {
    SPI_ADDR = 2'b00,
    SPI_WRITE = 2'b01,
    SPI_READ = 2'b11
  } rtccsr_spi_e;
  // one register write handed from the link to the system side
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] data;
  } rtccsr_wr_s;
  // frozen register image read by the link
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] stat;
    logic [7:0] tcr;
  } rtccsr_snap_s;
endpackage

// ==== src/rtccsr_regs.sv ====
// rtccsr_regs: control/status/trickle registers behind a serial link.
// assumes: host drives csn/sclk/sdi; sdo and the open-drain pins are
// resolved outside from their enables; sclk stops outside frames.
// What this block does
// - oscillator halts only on backup when disabled
// - control powers up 0x18
// - output floats on backup unless enabled
// - rate bits pick 1hz/4k/8k/32k
// - mode 0 gives square wave while oscillator on
// - alarm flag sets regardless of output mode
// - irq pin needs flag and enable, plus mode in the combined variant
// - no-output variant keeps bits as storage
// - split variant: bit 2 low enables wave
// - stop flag sets when oscillator stops
// - stop flag cleared only by writing zero
// - alarm flag reads one after match
// - alarm flag cleared only by writing zero
// - charger needs key 1010 in bits 7:4
// - diode field 01 none, 10 one
// - resistor field 01/10/11, 00 off
// - trickle register powers up zero
// - write bits latched on sampling edge
// - read bits shifted on opposite edge
// - sdo floats until read byte ready
// - fixed-zero bits always read zero
// - address first, msb write, wrapping increment
`timescale 1ns/1ps
`default_nettype none
module rtccsr_regs
  import rtccsr_pkg::*;
#(
  parameter logic CPOL = 1'b0,
  parameter logic CPHA = 1'b1,
  parameter logic [1:0] VARIANT = VAR_COMBINED
)
(
  // system clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // serial link
  input wire logic sclk,
  input wire logic csn,
  input wire logic sdi,
  output logic sdo_r,
  output logic sdoOe_r,
  // supply, crystal and alarm
  input wire logic vccValid,
  input wire logic oscRunning,
  input wire logic xtalClk,
  input wire logic alarmMatch,
  // oscillator and pins
  output logic oscEnable_r,
  output logic waveIrqOe_r,
  output logic sqwOe_r,
  // trickle charger
  output logic chargerOn_r,
  output logic diodeOn_r,
  output logic [1:0] resSel_r
);

  // sampling edge becomes the rising edge of sclkS
  localparam logic SAMPLE_INV = CPOL ^ CPHA;

  // link-domain state
  logic sclkS; // sclk turned so sampling is rising
  logic spiRstN; // frame reset: power reset or csn high
  logic [2:0] bitCnt_r; // bit within current byte
  logic [6:0] rxSh_r; // bits received so far
  logic [7:0] rxByte; // byte completed on this edge
  logic byteEnd; // eighth bit being sampled
  rtccsr_spi_e state_r; // frame phase
  rtccsr_spi_e state_nxt;
  logic [3:0] ptr_r; // register pointer
  logic [3:0] ptr_nxt;
  rtccsr_wr_s wrReq_r; // last complete write byte
  logic wrTgl_r; // flips once per write byte
  logic [7:0] txSh_r; // read shifter
  logic [7:0] rdByte; // register picked by ptr_r
  logic loadTx; // start of a read byte

  // system-domain state
  logic [AS_N-1:0] asyncIn;
  logic [AS_N-1:0] syncA_r; // first stage, read only by syncB
  logic [AS_N-1:0] syncB_r;
  logic [AS_N-1:0] syncC_r;
  logic [AS_N-1:0] settled_r; // agreed value of each input
  logic [AS_N-1:0] chg; // settled value about to change
  logic wrEv; // a write byte has arrived
  logic oscFell; // oscillator went from run to stop
  logic xtalRise; // crystal rising edge
  logic [7:0] ctrl_r;
  logic [7:0] ctrl_nxt;
  logic osf_r;
  logic osf_nxt;
  logic af_r;
  logic af_nxt;
  logic [7:0] tcr_r;
  logic [7:0] tcr_nxt;
  logic [7:0] statByte;
  logic ctrlWr;
  logic statWr;
  logic tcrWr;
  rtccsr_snap_s snap_r; // image frozen while csn is low
  logic [DIV_W-1:0] div_r; // crystal divider
  logic [DIV_W-1:0] div_nxt;
  logic sqwLvl; // selected square-wave level
  logic pwrOk; // pins may be driven
  logic oscOn; // oscillator is enabled
  logic irqAct; // alarm interrupt asserted
  logic waveOe_nxt;
  logic sqwOe_nxt;
  logic chgOn_nxt;

  // link clock and frame reset
  assign sclkS = sclk ^ SAMPLE_INV;
  assign spiRstN = rstn & ~csn;

  // receive decode
  assign rxByte = {rxSh_r, sdi};
  assign byteEnd = (bitCnt_r == 3'h7);
  // first byte selects direction and pointer
  assign state_nxt = (state_r != SPI_ADDR) ? state_r :
    (rxByte[WR_BIT] ? SPI_WRITE : SPI_READ);
  // pointer wraps in 16: 0f->00 on reads, 8f->80 on writes
  assign ptr_nxt = (state_r == SPI_ADDR) ? rxByte[3:0] :
    ptr_r + 4'h1;

  // sampling edge: shift in, advance phase and pointer
  always_ff @(posedge sclkS or negedge spiRstN)
  begin
    if (!spiRstN)
    begin
      bitCnt_r <= 3'h0;
      rxSh_r <= 7'h00;
      state_r <= SPI_ADDR;
      ptr_r <= 4'h0;
    end
    else
    begin
      bitCnt_r <= bitCnt_r + 3'h1;
      rxSh_r <= rxByte[6:0];
      // advance only on whole bytes
      if (byteEnd)
      begin
        state_r <= state_nxt;
        ptr_r <= ptr_nxt;
      end
    end
  end

  // write handoff survives csn rising, so only power reset clears it
  always_ff @(posedge sclkS or negedge rstn)
  begin
    if (!rstn)
    begin
      wrReq_r <= '0;
      wrTgl_r <= 1'b0;
    end
    else if (byteEnd && state_r == SPI_WRITE)
    begin
      // whole byte only; partial bytes are dropped at csn high
      wrReq_r <= '{addr: ptr_r, data: rxByte};
      wrTgl_r <= ~wrTgl_r;
    end
  end

  // read mux over the frozen image; other addresses read zero
  assign rdByte = (ptr_r == ADDR_CTRL) ? snap_r.ctrl :
    (ptr_r == ADDR_STAT) ? snap_r.stat :
    (ptr_r == ADDR_TCR) ? snap_r.tcr : 8'h00;
  assign loadTx = (state_r == SPI_READ) && (bitCnt_r == 3'h0);

  // shift edge: load a whole byte, then shift msb first
  always_ff @(negedge sclkS or negedge spiRstN)
  begin
    if (!spiRstN)
    begin
      txSh_r <= 8'h00;
      sdo_r <= 1'b0;
      sdoOe_r <= 1'b0;
    end
    else if (loadTx)
    begin
      // drive starts only with a full byte in hand
      txSh_r <= {rdByte[6:0], 1'b0};
      sdo_r <= rdByte[7];
      sdoOe_r <= 1'b1;
    end
    else
    begin
      sdo_r <= txSh_r[7];
      txSh_r <= {txSh_r[6:0], 1'b0};
    end
  end

  // inputs from other domains
  assign asyncIn = {xtalClk, oscRunning, vccValid, wrTgl_r, csn};

  // three-stage sync per input; accept once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < AS_N; gi++)
    begin : g_sync
      assign chg[gi] = (syncB_r[gi] == syncC_r[gi]) &&
        (syncC_r[gi] != settled_r[gi]);
      always_ff @(posedge clk_sys or negedge rstn)
      begin
        if (!rstn)
        begin
          syncA_r[gi] <= AS_RST[gi];
          syncB_r[gi] <= AS_RST[gi];
          syncC_r[gi] <= AS_RST[gi];
          settled_r[gi] <= AS_RST[gi];
        end
        else
        begin
          syncA_r[gi] <= asyncIn[gi];
          syncB_r[gi] <= syncA_r[gi];
          syncC_r[gi] <= syncB_r[gi];
          // a change counts once the last two stages agree
          if (chg[gi])
          begin
            settled_r[gi] <= syncC_r[gi];
          end
        end
      end
    end
  endgenerate

  // events derived from settled inputs
  assign wrEv = chg[AS_WTGL];
  assign oscFell = chg[AS_OSC] & ~syncC_r[AS_OSC];
  assign xtalRise = chg[AS_XTAL] & syncC_r[AS_XTAL];

  // register write decode
  assign ctrlWr = wrEv && (wrReq_r.addr == ADDR_CTRL);
  assign statWr = wrEv && (wrReq_r.addr == ADDR_STAT);
  assign tcrWr = wrEv && (wrReq_r.addr == ADDR_TCR);

  // fixed-zero control bits are masked off on write
  assign ctrl_nxt = ctrlWr ? (wrReq_r.data & CTRL_WMASK) :
    ctrl_r;
  // flags: writing 0 clears, 1 is ignored, a new event wins
  assign osf_nxt = oscFell |
    (osf_r & ~(statWr & ~wrReq_r.data[STAT_OSF]));
  assign af_nxt = alarmMatch |
    (af_r & ~(statWr & ~wrReq_r.data[STAT_AF]));
  assign tcr_nxt = tcrWr ? wrReq_r.data : tcr_r;
  assign statByte = {osf_r, 6'h00, af_r};

  // register storage
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl_r <= CTRL_RST;
      osf_r <= STAT_RST[STAT_OSF];
      af_r <= STAT_RST[STAT_AF];
      tcr_r <= TCR_RST;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      osf_r <= osf_nxt;
      af_r <= af_nxt;
      tcr_r <= tcr_nxt;
    end
  end

  // image for the link; frozen while a frame is open so the
  // link never sees a word mid-change
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      snap_r <= '{ctrl: CTRL_RST, stat: STAT_RST, tcr: TCR_RST};
    end
    else if (settled_r[AS_CSN])
    begin
      snap_r <= '{ctrl: ctrl_r, stat: statByte, tcr: tcr_r};
    end
  end

  // crystal divider for the slower rates
  assign div_nxt = xtalRise ? div_r + 1'b1 : div_r;
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      div_r <= '0;
    end
    else
    begin
      div_r <= div_nxt;
    end
  end

  // rate select
  assign sqwLvl =
    (ctrl_r[CTRL_RSH:CTRL_RSL] == RATE_1HZ) ? div_r[TAP_1HZ] :
    (ctrl_r[CTRL_RSH:CTRL_RSL] == RATE_4K) ? div_r[TAP_4K] :
    (ctrl_r[CTRL_RSH:CTRL_RSL] == RATE_8K) ? div_r[TAP_8K] :
    settled_r[AS_XTAL];

  // power and oscillator state
  assign oscOn = settled_r[AS_VCC] | ~ctrl_r[CTRL_OSCD];
  assign pwrOk = settled_r[AS_VCC] | ctrl_r[CTRL_BBO];
  assign irqAct = af_r & ctrl_r[CTRL_AIE];

  // open-drain pins pull low while their enable is high
  assign waveOe_nxt = (VARIANT == VAR_NO_OUT) ? 1'b0 :
    (VARIANT == VAR_SPLIT) ? (pwrOk & irqAct) :
    ctrl_r[CTRL_MODE] ? (pwrOk & irqAct) :
    (pwrOk & oscOn & ~sqwLvl);
  // split variant: bit 2 low enables the wave pin
  assign sqwOe_nxt = (VARIANT == VAR_SPLIT) &&
    pwrOk && oscOn && !ctrl_r[CTRL_MODE] && !sqwLvl;

  // charger key, diode and resistor all must be legal
  assign chgOn_nxt = (tcr_r[7:4] == TCR_KEY) &&
    (tcr_r[3:2] == DS_NONE || tcr_r[3:2] == DS_ONE) &&
    (tcr_r[1:0] != RESISTOR_SELECT_FIELD_OFF);

  // registered outputs
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      oscEnable_r <= 1'b1;
      waveIrqOe_r <= 1'b0;
      sqwOe_r <= 1'b0;
      chargerOn_r <= 1'b0;
      diodeOn_r <= 1'b0;
      resSel_r <= 2'h0;
    end
    else
    begin
      oscEnable_r <= oscOn;
      waveIrqOe_r <= waveOe_nxt;
      sqwOe_r <= sqwOe_nxt;
      chargerOn_r <= chgOn_nxt;
      // selections show zero while the charger is off
      diodeOn_r <= chgOn_nxt & (tcr_r[3:2] == DS_ONE);
      resSel_r <= chgOn_nxt ? tcr_r[1:0] : 2'h0;
    end
  end

  // checks on the system domain
  chk_osc_main_run: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    settled_r[AS_VCC] |=> oscEnable_r)
    else $error("oscillator off with main supply");

  chk_osf_sets: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    oscFell |=> osf_r)
    else $error("stop flag missed");

  chk_osf_sticky: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    osf_r && !(statWr && !wrReq_r.data[STAT_OSF]) |=> osf_r)
    else $error("stop flag dropped");

  chk_af_sets: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    alarmMatch |=> af_r && statByte[STAT_AF])
    else $error("alarm flag missed");

  chk_af_sticky: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    af_r && !alarmMatch && !statWr |=> af_r)
    else $error("alarm flag dropped");

  chk_irq_gate: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    (VARIANT == VAR_COMBINED) && ctrl_r[CTRL_MODE] &&
    !(af_r && ctrl_r[CTRL_AIE]) |=> !waveIrqOe_r)
    else $error("irq without flag and enable");

  chk_backup_float: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    !settled_r[AS_VCC] && !ctrl_r[CTRL_BBO] |=>
    !waveIrqOe_r && !sqwOe_r)
    else $error("pin driven on backup");

  chk_charger_key: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    $rose(chargerOn_r) |-> $past(tcr_r[7:4]) == TCR_KEY &&
    $past(tcr_r[1:0]) != RESISTOR_SELECT_FIELD_OFF)
    else $error("charger on without key");

  chk_zero_bits: assert property (
    @(posedge clk_sys) disable iff (!rstn)
    ctrl_r[6] == 1'b0 && ctrl_r[1] == 1'b0 &&
    snap_r.stat[6:1] == 6'h00)
    else $error("fixed-zero bit set");

  // check on the link domain
  chk_sdo_quiet: assert property (
    @(posedge sclkS) disable iff (!spiRstN)
    state_r != SPI_READ |-> !sdoOe_r)
    else $error("sdo driven outside read");

endmodule
`default_nettype wire

// ==== bench/rtccsr_host.sv ====
// rtccsr_host: spi host model for the register block, mode 1 only.
// assumes: the bench calls its tasks; sclk idles low between frames.
`timescale 1ns/1ps
`default_nettype none
module rtccsr_host
(
  // link out
  output logic sclk,
  output logic csn,
  output logic sdi,
  // link in
  input wire logic sdo,
  input wire logic sdoOe
);
  logic lastBit; // last data line level seen
  initial
  begin
    sclk = 1'b0;
    csn = 1'b1;
    sdi = 1'b0;
    lastBit = 1'b0;
  end
  // odd offset keeps sclk edges off the system clock grid
  task start();
    #19 csn = 1'b0;
    #13;
  endtask
  task stop();
    #16 csn = 1'b1;
  endtask
  // msb first; a short count leaves a partial byte behind
  task xfer(input logic [7:0] tx, input int nb,
    output logic [7:0] rx, output logic [7:0] oe);
    rx = 8'h00;
    oe = 8'h00;
    for (int i = 7; i > 7 - nb; i--)
    begin
      sclk = 1'b1; // shift edge
      #1 sdi = tx[i];
      #15 sclk = 1'b0; // sampling edge
      // a released line flips so a stale bit never passes
      lastBit = sdoOe ? sdo : ~lastBit;
      rx[i] = lastBit;
      oe[i] = sdoOe;
      #16;
    end
  endtask
endmodule
`default_nettype wire

// ==== bench/testbench.sv ====
// testbench: random and directed checks of the register block.
// assumes: design in default spi mode 1, combined output variant.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) \
  begin \
    nTests++; \
    if ((got) !== (ex)) \
    begin \
      mismatches++; \
      $display("wrong value %s exp %h got %h", nm, ex, got); \
    end \
  end
module testbench;
  import rtccsr_pkg::*;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic vccValid = 1'b1;
  logic oscRunning = 1'b1;
  logic alarmMatch = 1'b0;
  logic [4:0] xDiv = 5'h00; // crystal stand-in, fast to keep runs short
  wire logic sclk, csn, sdi;
  logic sdo_r, sdoOe_r, oscEnable_r, waveIrqOe_r, sqwOe_r;
  logic chargerOn_r, diodeOn_r;
  logic [1:0] resSel_r;
  logic [3:0] chgPins; // charger pins gathered for one compare
  assign chgPins = {chargerOn_r, diodeOn_r, resSel_r};
  int per; // measured wave period in system cycles
  // crystal stand-in period in system cycles (xDiv bit 4)
  localparam int XPER = 32;
  int mismatches = 0;
  int nTests = 0;
  logic [31:0] seed = 32'h28;
  logic [7:0] rx, oe, v;

  always #4 clk_sys = ~clk_sys;
  always @(posedge clk_sys)
    xDiv <= xDiv + 5'h01;

  rtccsr_regs DUT (.clk_sys(clk_sys), .rstn(rstn), .sclk(sclk),
    .csn(csn), .sdi(sdi), .sdo_r(sdo_r), .sdoOe_r(sdoOe_r),
    .vccValid(vccValid), .oscRunning(oscRunning), .xtalClk(xDiv[4]),
    .alarmMatch(alarmMatch), .oscEnable_r(oscEnable_r),
    .waveIrqOe_r(waveIrqOe_r), .sqwOe_r(sqwOe_r),
    .chargerOn_r(chargerOn_r), .diodeOn_r(diodeOn_r),
    .resSel_r(resSel_r));
  rtccsr_host host (.sclk(sclk), .csn(csn), .sdi(sdi), .sdo(sdo_r),
    .sdoOe(sdoOe_r));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  // expected {on, diode, resistor} for a trickle byte
  function automatic logic [3:0] tcExp(input logic [7:0] b);
    logic on;
    on = b[7:4] == 4'ha && (b[3:2] == 2'h1 || b[3:2] == 2'h2)
      && b[1:0] != 2'h0;
    return {on, on && b[3:2] == 2'h2, on ? b[1:0] : 2'h0};
  endfunction
  // expected wave period: crystal period times 32.768k over the rate
  function automatic int sqwPer(input logic [1:0] rs);
    return XPER * ((rs == 2'h3) ? 1 : (rs == 2'h2) ? 4 :
      (rs == 2'h1) ? 8 : 32768);
  endfunction
  // cycles up to the next rising edge of the wave/irq pin enable;
  // an unknown level never counts as an edge, so it times out
  task waveEdge(output int t);
    logic prev;
    prev = waveIrqOe_r;
    t = 0;
    while (t < 600 && !(waveIrqOe_r === 1'b1 && prev === 1'b0))
    begin
      prev = waveIrqOe_r;
      @(posedge clk_sys);
      #1;
      t++;
    end
    if (!(waveIrqOe_r === 1'b1 && prev === 1'b0))
    begin
      mismatches++;
      tally_and_finish();
    end
  endtask
  task tally_and_finish();
    $display("checks %0d mismatches %0d", nTests, mismatches);
    if (mismatches == 0 && nTests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // spacing between frames; also covers the write crossing latency;
  // ends off the edge so registered outputs are read settled
  task gap();
    repeat (12) @(posedge clk_sys);
    #1;
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    host.start();
    host.xfer({4'h8, a}, 8, rx, oe);
    host.xfer(d, 8, rx, oe);
    host.stop();
    gap();
  endtask
  // burst read of n bytes, expectations packed first byte highest
  task rd(input logic [3:0] a, input int n, input logic [23:0] e);
    host.start();
    host.xfer({4'h0, a}, 8, rx, oe);
    `CHK("sdo enable in address", 8'h00, oe)
    for (int i = 0; i < n; i++)
    begin
      host.xfer(8'h00, 8, rx, oe);
      `CHK("sdo enable in read", 8'hff, oe)
      `CHK("read data", e[23-8*i -: 8], rx)
    end
    host.stop();
    gap();
  endtask
  task setVcc(input logic b);
    @(posedge clk_sys);
    vccValid <= b;
    gap();
  endtask
  task pulse();
    @(posedge clk_sys);
    alarmMatch <= 1'b1;
    @(posedge clk_sys);
    alarmMatch <= 1'b0;
    gap();
  endtask

  // watchdog: a hang counts as a mismatch
  initial
  begin
    #400000;
    mismatches++;
    tally_and_finish();
  end

  initial
  begin
    repeat (10) @(posedge clk_sys);
    rstn <= 1'b1;
    gap();
    rd(ADDR_CTRL, 3, {8'h18, 8'h80, 8'h00});
    `CHK("charger at reset", 4'h0, chgPins)
    // random control bytes; fixed-zero bits must drop
    for (int i = 0; i < 6; i++)
    begin
      seed = xs(seed);
      wr(ADDR_CTRL, seed[7:0]);
      rd(ADDR_CTRL, 1, {seed[7:0] & 8'hbd, 16'h0});
    end
    // every diode/resistor code under the key, then random keys
    for (int i = 0; i < 24; i++)
    begin
      seed = xs(seed);
      v = (i < 16) ? {4'ha, i[3:0]} : seed[7:0];
      wr(ADDR_TCR, v);
      `CHK("charger pins", tcExp(v), chgPins)
    end
    // partial byte must not land
    host.start();
    host.xfer(8'h8f, 8, rx, oe);
    host.xfer(8'h5a, 5, rx, oe);
    host.stop();
    gap();
    rd(ADDR_TCR, 2, {v, 16'h0});
    // burst write across all three registers
    host.start();
    host.xfer(8'h8d, 8, rx, oe);
    host.xfer(8'h18, 8, rx, oe);
    host.xfer(8'h7f, 8, rx, oe);
    host.xfer(8'ha9, 8, rx, oe);
    host.stop();
    gap();
    rd(ADDR_CTRL, 3, {8'h18, 8'h00, 8'ha9});
    // oscillator stop sets the flag; writing ones keeps it
    @(posedge clk_sys);
    oscRunning <= 1'b0;
    gap();
    @(posedge clk_sys);
    oscRunning <= 1'b1;
    gap();
    wr(ADDR_STAT, 8'hff);
    rd(ADDR_STAT, 1, {8'h80, 16'h0});
    pulse();
    rd(ADDR_STAT, 1, {8'h81, 16'h0});
    wr(ADDR_STAT, 8'h01);
    rd(ADDR_STAT, 1, {8'h01, 16'h0});
    // interrupt output with flag still set
    wr(ADDR_CTRL, 8'h25);
    `CHK("irq pin", 1'b1, waveIrqOe_r)
    setVcc(1'b0);
    `CHK("irq on backup enabled", 1'b1, waveIrqOe_r)
    setVcc(1'b1);
    wr(ADDR_CTRL, 8'h05);
    setVcc(1'b0);
    `CHK("irq on backup released", 1'b0, waveIrqOe_r)
    setVcc(1'b1);
    wr(ADDR_CTRL, 8'h04);
    `CHK("irq masked", 1'b0, waveIrqOe_r)
    // oscillator disable only bites on backup
    wr(ADDR_CTRL, 8'h84);
    `CHK("osc on main", 1'b1, oscEnable_r)
    setVcc(1'b0);
    `CHK("osc off on backup", 1'b0, oscEnable_r)
    setVcc(1'b1);
    `CHK("osc back on main", 1'b1, oscEnable_r)
    // wave mode: full period per rate, the 1 hz rate is too slow here
    for (int r = 3; r > 0; r--)
    begin
      wr(ADDR_CTRL, {3'h0, r[1:0], 3'h0});
      waveEdge(per);
      waveEdge(per);
      `CHK("wave period", sqwPer(r[1:0]), per)
    end
    // wave must stop with the oscillator disabled on backup
    wr(ADDR_CTRL, 8'hb8);
    setVcc(1'b0);
    v[0] = 1'b0;
    repeat (64)
    begin
      @(posedge clk_sys);
      #1;
      v[0] = v[0] | waveIrqOe_r;
    end
    `CHK("wave with oscillator off", 1'b0, v[0])
    setVcc(1'b1);
    `CHK("split pin idle", 1'b0, sqwOe_r)
    // second reset in mid-run restores first-power-up values
    @(posedge clk_sys);
    rstn <= 1'b0;
    repeat (10) @(posedge clk_sys);
    rstn <= 1'b1;
    gap();
    rd(ADDR_CTRL, 3, {8'h18, 8'h80, 8'h00});
    `CHK("charger after reset", 4'h0, chgPins)
    tally_and_finish();
  end
endmodule
`default_nettype wire
